// ===== pkg/ushr_pkg.sv
// Shared constants and types for the high-speed mode detect block
package ushr_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CHIRP_MIN_NS  = 18000;
	localparam int CHIRP_MAX_NS  = 128000;
	// Least time rounds up, longest time rounds down
	localparam int CHIRP_MIN_CYC =
		(CHIRP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CHIRP_MAX_CYC = CHIRP_MAX_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	localparam int SYNC_STAGES = 2;
	localparam int SYNC_WIDTH  = 16;

	// ----------------------------------------------------------------
	// Serial target
	// ----------------------------------------------------------------
	localparam logic [6:0] SER_ADDR      = 7'h2C;
	localparam logic [3:0] SER_BYTE_BITS = 4'h8;
	localparam logic [7:0] SER_CFG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Strap settings
	// ----------------------------------------------------------------
	localparam logic [1:0] AC_BOOST_MAX = 2'h3;

	typedef enum logic [1:0] {
		DC_GAIN_40MV = 2'b00,
		DC_GAIN_60MV = 2'b01,
		DC_GAIN_80MV = 2'b10
	} ushr_dc_gain_type;

	// ----------------------------------------------------------------
	// Channel and serial target states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CH_UNCONN  = 3'b000,
		CH_FIXTURE = 3'b001,
		CH_CONN    = 3'b010,
		CH_CHIRP_J = 3'b011,
		CH_CHIRP_K = 3'b100,
		CH_HS_WAIT = 3'b101,
		CH_HS      = 3'b110
	} ushr_chan_state_type;

	typedef enum logic [2:0] {
		SER_IDLE    = 3'b000,
		SER_ADDR_RX = 3'b001,
		SER_ACK_ADR = 3'b010,
		SER_WR_RX   = 3'b011,
		SER_ACK_WR  = 3'b100,
		SER_RD_TX   = 3'b101,
		SER_ACK_RD  = 3'b110
	} ushr_ser_state_type;

endpackage : ushr_pkg

// ===== testbench/ushr_mode_detect_props.sv
// Port-level assertions for the mode detect block
`timescale 1ns/1ns
`default_nettype none
module ushr_mode_detect_props
	import ushr_pkg::*;
#(
	parameter int CHIRP_MIN_CYCLES = 10,
	parameter int CHIRP_MAX_CYCLES = 40
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	// Pins
	input  wire logic                  sda_oe,
	input  wire logic                  scl_out,
	input  wire logic                  scl_oe,
	input  wire logic                  dc_gain_strap_high,
	input  wire logic                  dc_gain_strap_float,
	input  wire logic                  dc_gain_strap_out,
	input  wire logic                  dc_gain_strap_oe,
	input  wire logic [1:0]            ac_boost_select,
	input  wire logic                  ac_boost_float,
	// Detectors
	input  wire logic                  dp_pullup_det,
	input  wire logic                  dm_pullup_det,
	input  wire logic                  disconnect_det,
	input  wire logic                  squelch_det,
	input  wire logic                  test_packet_det,
	// Status
	input  wire logic                  high_speed_flag,
	input  wire logic                  connection_flag,
	input  wire logic                  core_regulator_out,
	input  wire logic                  serial_mode,
	input  wire logic                  straps_valid,
	input  wire logic [1:0]            ac_boost_setting,
	input  wire ushr_pkg::ushr_dc_gain_type dc_gain_setting
);
	import ushr_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	reset_quiet_a: assert property (disable iff (1'b0)
		!rst_n |-> !high_speed_flag && !connection_flag && !scl_oe
			&& !dc_gain_strap_oe && !sda_oe && !core_regulator_out)
		else $error("output active in reset");
	ac_capture_a: assert property (
		$rose(straps_valid) |-> ac_boost_setting == ($past(ac_boost_float)
			? AC_BOOST_MAX : $past(ac_boost_select)))
		else $error("ac boost capture wrong");
	dc_capture_a: assert property (
		$rose(straps_valid) && !serial_mode |-> dc_gain_setting ==
			($past(dc_gain_strap_float) ? DC_GAIN_60MV :
			$past(dc_gain_strap_high) ? DC_GAIN_80MV : DC_GAIN_40MV))
		else $error("dc gain capture wrong");
	straps_hold_a: assert property (
		straps_valid && $past(straps_valid) |->
			$stable({ac_boost_setting, dc_gain_setting, serial_mode}))
		else $error("strap setting moved");
	hs_pin_a: assert property (
		straps_valid && $past(straps_valid) && !serial_mode |->
			dc_gain_strap_oe && dc_gain_strap_out == high_speed_flag)
		else $error("high speed pin wrong");
	cd_pin_a: assert property (
		straps_valid && $past(straps_valid) && !serial_mode |->
			scl_oe && scl_out == connection_flag)
		else $error("connection pin wrong");
	serial_pins_a: assert property (
		serial_mode |-> !scl_oe && !dc_gain_strap_oe)
		else $error("flag pin driven in serial mode");
	strap_sda_a: assert property (
		!serial_mode |-> !sda_oe)
		else $error("data pin driven in strap mode");
	regulator_a: assert property (
		core_regulator_out == high_speed_flag)
		else $error("regulator not tied to high speed");
	hs_cause_a: assert property (
		$rose(high_speed_flag) |->
			$past(squelch_det, 3) || $past(test_packet_det, 3))
		else $error("high speed without cause");
	attach_seen_a: assert property (
		(straps_valid && !disconnect_det
			&& (dp_pullup_det || dm_pullup_det))[*3] |=> connection_flag)
		else $error("attach missed");
	detach_seen_a: assert property (
		(straps_valid && disconnect_det)[*3] |=>
			!connection_flag && !high_speed_flag)
		else $error("detach missed");
endmodule : ushr_mode_detect_props

bind ushr_mode_detect ushr_mode_detect_props #(
	.CHIRP_MIN_CYCLES(CHIRP_MIN_CYCLES),
	.CHIRP_MAX_CYCLES(CHIRP_MAX_CYCLES)
) ushr_mode_detect_props_inst (.*);
`default_nettype wire

// ===== testbench/ushr_mode_detect_tb.sv
// Self-checking bench for the mode detect block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module ushr_mode_detect_tb;
	import ushr_pkg::*;
	logic             sys_clk = 1'h0;
	logic             rst_n, sda_m, scl_m, sda_in, sda_out, sda_oe;
	logic             scl_in, scl_out, scl_oe, ac_boost_float;
	logic             dc_gain_strap_high, dc_gain_strap_float;
	logic             dc_gain_strap_out, dc_gain_strap_oe;
	logic [1:0]       ac_boost_select, ac_boost_setting;
	logic             dp_pullup_det, dm_pullup_det, disconnect_det;
	logic             bus_reset_det, chirp_j_det, chirp_k_det;
	logic             squelch_det, fixture_det, test_packet_det;
	logic             high_speed_flag, connection_flag, core_regulator_out;
	logic             serial_mode, straps_valid;
	ushr_dc_gain_type dc_gain_setting;
	logic [7:0]       serial_config;
	logic [31:0]      seed = 32'h0000001B;
	int               n_mismatch = 0;
	int               n_checks = 0;

	// Open-drain data line; flag pin drives the clock line in strap mode
	assign sda_in = sda_m & ~sda_oe;
	assign scl_in = scl_oe ? scl_out : scl_m;
	always #5 sys_clk = ~sys_clk;

	ushr_mode_detect #(.CHIRP_MIN_CYCLES(10), .CHIRP_MAX_CYCLES(40))
		ushr_mode_detect_inst (.*);
	ushr_usb_partner ushr_usb_partner_inst (.*);

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic ushr_dc_gain_type exp_dc(input logic h, input logic f);
		return f ? DC_GAIN_60MV : (h ? DC_GAIN_80MV : DC_GAIN_40MV);
	endfunction : exp_dc
	function automatic logic [1:0] exp_ac(input logic [1:0] s, input logic f);
		return f ? AC_BOOST_MAX : s;
	endfunction : exp_ac
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	// Enable stays low far longer than the supply needs to settle
	task automatic do_reset();
		rst_n <= 1'h0;
		tick(12);
		@(negedge sys_clk);
		`CHK({connection_flag, high_speed_flag, scl_oe}, 3'h0)
		`CHK({dc_gain_strap_oe, sda_oe, core_regulator_out}, 3'h0)
		@(posedge sys_clk);
		rst_n <= 1'h1;
		tick(6);
		@(negedge sys_clk);
		`CHK({straps_valid, serial_mode}, {1'h1, sda_m & scl_m})
		`CHK(ac_boost_setting, exp_ac(ac_boost_select, ac_boost_float))
		@(posedge sys_clk);
	endtask : do_reset
	task automatic i2c_bit(input logic b, output logic r);
		sda_m <= b;
		tick(6);
		scl_m <= 1'h1;
		tick(3);
		r = sda_in;
		tick(3);
		scl_m <= 1'h0;
		tick(3);
	endtask : i2c_bit
	task automatic i2c_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int k = 7; k >= 0; k--) i2c_bit(b[k], r);
		i2c_bit(1'h1, r);
		ack = !r;
	endtask : i2c_byte
	// Start when s is set, otherwise stop
	task automatic i2c_edge(input logic s);
		{sda_m, scl_m} <= {s, 1'h0};
		tick(6);
		scl_m <= 1'h1;
		tick(6);
		sda_m <= s ? 1'h0 : 1'h1;
		tick(6);
		scl_m <= !s;
		tick(3);
	endtask : i2c_edge

	initial begin
		logic [31:0] r;
		logic [1:0]  e_ac;
		logic        ack;
		// Reset is first asserted by do_reset, so the flops see its edge
		{sda_m, scl_m, ac_boost_float, ac_boost_select} = 4'h0;
		{dc_gain_strap_high, dc_gain_strap_float} = 2'h0;
		// Every strap level, then a late pin change that must not stick
		for (int i = 0; i < 6; i++) begin
			r = rnd();
			dc_gain_strap_high <= (i % 3) == 0;
			dc_gain_strap_float <= (i % 3) == 1;
			{ac_boost_float, ac_boost_select} <= i < 2 ? 3'(i * 4) : r[2:0];
			do_reset();
			`CHK(dc_gain_setting, exp_dc(dc_gain_strap_high, dc_gain_strap_float))
			e_ac = exp_ac(ac_boost_select, ac_boost_float);
			{ac_boost_float, ac_boost_select} <= ~{ac_boost_float, ac_boost_select};
			tick(6);
			@(negedge sys_clk);
			`CHK(ac_boost_setting, e_ac)
			@(posedge sys_clk);
		end
		$display("done: straps");
		r = rnd();
		ushr_usb_partner_inst.attach(r[0]);
		@(negedge sys_clk);
		`CHK({connection_flag, scl_out, scl_oe}, 3'h7)
		ushr_usb_partner_inst.handshake(10, 10 + int'(r[7:3]) % 31);
		@(negedge sys_clk);
		`CHK({high_speed_flag, dc_gain_strap_out, core_regulator_out}, 3'h7)
		for (int i = 0; i < 3; i++) begin
			ushr_usb_partner_inst.handshake(i == 0 ? 5 : (i == 1 ? 50 : 20),
				i == 2 ? 5 : 20);
			@(negedge sys_clk);
			`CHK({high_speed_flag, connection_flag, core_regulator_out}, 3'h2)
		end
		ushr_usb_partner_inst.unplug();
		@(negedge sys_clk);
		`CHK({connection_flag, scl_out, high_speed_flag}, 3'h0)
		ushr_usb_partner_inst.fixture();
		@(negedge sys_clk);
		`CHK({high_speed_flag, core_regulator_out, dc_gain_strap_out}, 3'h7)
		@(posedge sys_clk);
		do_reset();
		`CHK({connection_flag, high_speed_flag}, 2'h0)
		$display("done: channel");
		{sda_m, scl_m} <= 2'h3;
		do_reset();
		`CHK({serial_mode, scl_oe, dc_gain_strap_oe}, 3'h4)
		i2c_edge(1'h1);
		i2c_byte({SER_ADDR, 1'h0}, ack);
		`CHK(ack, 1'h1)
		i2c_byte(r[15:8], ack);
		`CHK(ack, 1'h1)
		i2c_edge(1'h0);
		`CHK(serial_config, r[15:8])
		i2c_edge(1'h1);
		i2c_byte(8'h5A, ack);
		`CHK(ack, 1'h0)
		i2c_edge(1'h0);
		`CHK(serial_config, r[15:8])
		// Read back the status with a device attached, then not-acknowledge
		ushr_usb_partner_inst.attach(1'h0);
		i2c_edge(1'h1);
		i2c_byte({SER_ADDR, 1'h1}, ack);
		`CHK(ack, 1'h1)
		for (int k = 7; k >= 0; k--) i2c_bit(1'h1, r[k]);
		i2c_bit(1'h1, ack);
		i2c_edge(1'h0);
		`CHK(r[7:0], {2'h0, 1'h0, 1'h1, 1'h0, CH_CONN})
		$display("done: serial");
		final_report();
	end

	// The sequence takes under 3000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		final_report();
	end
endmodule : ushr_mode_detect_tb
`default_nettype wire

// ===== testbench/ushr_usb_partner.sv
// Line activity of the host and device as seen by the detectors
`timescale 1ns/1ns
`default_nettype none
module ushr_usb_partner (
	// Clock
	input  wire logic sys_clk,
	// Detector levels
	output logic      dp_pullup_det,
	output logic      dm_pullup_det,
	output logic      disconnect_det,
	output logic      bus_reset_det,
	output logic      chirp_j_det,
	output logic      chirp_k_det,
	output logic      squelch_det,
	output logic      fixture_det,
	output logic      test_packet_det
);
	initial begin
		{dp_pullup_det, dm_pullup_det, disconnect_det} = 3'h0;
		{bus_reset_det, chirp_j_det, chirp_k_det} = 3'h0;
		{squelch_det, fixture_det, test_packet_det} = 3'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic attach(input logic on_dm);
		tick(1);
		dp_pullup_det <= !on_dm;
		dm_pullup_det <= on_dm;
		tick(6);
	endtask : attach
	// Bus reset is short so an aborted J cannot start a new one
	task automatic handshake(input int j, input int k);
		tick(1);
		bus_reset_det <= 1'h1;
		chirp_j_det <= 1'h1;
		tick(4);
		bus_reset_det <= 1'h0;
		tick(j - 4);
		chirp_j_det <= 1'h0;
		chirp_k_det <= 1'h1;
		tick(k);
		chirp_k_det <= 1'h0;
		squelch_det <= 1'h1;
		tick(4);
		squelch_det <= 1'h0;
		tick(4);
	endtask : handshake
	task automatic fixture();
		tick(1);
		fixture_det <= 1'h1;
		tick(4);
		test_packet_det <= 1'h1;
		tick(4);
		{fixture_det, test_packet_det} <= 2'h0;
		tick(4);
	endtask : fixture
	task automatic unplug();
		tick(1);
		{dp_pullup_det, dm_pullup_det, disconnect_det} <= 3'h1;
		tick(4);
		disconnect_det <= 1'h0;
		tick(4);
	endtask : unplug
endmodule : ushr_usb_partner
`default_nettype wire

// ===== verilog/ushr_mode_detect.sv
// Mode detect, strap capture and serial target of the HS conditioner
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - A low enable input holds the whole block in reset and shutdown.
// - The AC boost selection is caught once after reset release only.
// - A floating AC boost selection picks the maximum boost.
// - In strap mode the DC gain pin is read as high 80, float 60, low 40 mV.
// - In strap mode the DC gain pin then drives the high-speed flag.
// - Fixture seen from unconnected, then test packet, sets high speed.
// - Squelch after a bus reset with a good handshake sets high speed.
// - A good handshake is one chirp J then one chirp K, each 18 to 128 us.
// - In strap mode the clock pin drives the connection flag on pull-up.
// - The connection flag drops when a disconnect is detected.
// - In serial mode the block answers as a two-wire target at 0x2C.
// - The core regulator is enabled only while in high-speed mode.
// - Both serial pins pulled up at reset selects serial mode.
module ushr_mode_detect
	import ushr_pkg::*;
#(
	parameter int CHIRP_MIN_CYCLES = ushr_pkg::CHIRP_MIN_CYC,
	parameter int CHIRP_MAX_CYCLES = ushr_pkg::CHIRP_MAX_CYC
) (
	// Clock and reset (reset is the active-low enable pin)
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	// Serial data pin
	input  wire logic                       sda_in,
	output logic                            sda_out,
	output logic                            sda_oe,
	// Serial clock pin, doubles as connection flag
	input  wire logic                       scl_in,
	output logic                            scl_out,
	output logic                            scl_oe,
	// DC gain strap pin, doubles as high-speed flag
	input  wire logic                       dc_gain_strap_high,
	input  wire logic                       dc_gain_strap_float,
	output logic                            dc_gain_strap_out,
	output logic                            dc_gain_strap_oe,
	// AC boost strap
	input  wire logic [1:0]                 ac_boost_select,
	input  wire logic                       ac_boost_float,
	// Channel line-state detectors
	input  wire logic                       dp_pullup_det,
	input  wire logic                       dm_pullup_det,
	input  wire logic                       disconnect_det,
	input  wire logic                       bus_reset_det,
	input  wire logic                       chirp_j_det,
	input  wire logic                       chirp_k_det,
	input  wire logic                       squelch_det,
	input  wire logic                       fixture_det,
	input  wire logic                       test_packet_det,
	// Status and settings
	output logic                            high_speed_flag,
	output logic                            connection_flag,
	output logic                            core_regulator_out,
	output logic                            serial_mode,
	output logic                            straps_valid,
	output logic [1:0]                      ac_boost_setting,
	output ushr_pkg::ushr_dc_gain_type      dc_gain_setting,
	output logic [7:0]                      serial_config
);

	import ushr_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	localparam int CNT_W = $clog2(CHIRP_MAX_CYCLES + 1);

	generate
		if (CHIRP_MIN_CYCLES < 1 || CHIRP_MAX_CYCLES <= CHIRP_MIN_CYCLES)
		begin : g_bad_chirp
			$error("chirp window parameters are not usable");
		end
	endgenerate

	localparam logic [CNT_W-1:0] MIN_CNT = CNT_W'(CHIRP_MIN_CYCLES);
	localparam logic [CNT_W-1:0] MAX_CNT = CNT_W'(CHIRP_MAX_CYCLES);
	localparam logic [CNT_W-1:0] ONE_CNT = CNT_W'(1);
	localparam logic [1:0]       SYNC_DONE = 2'(SYNC_STAGES);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_WIDTH-1:0] raw_pins;
	logic [SYNC_WIDTH-1:0] pins;

	assign raw_pins = {sda_in, scl_in, dc_gain_strap_high,
		dc_gain_strap_float, ac_boost_select, ac_boost_float,
		dp_pullup_det, dm_pullup_det, disconnect_det, bus_reset_det,
		chirp_j_det, chirp_k_det, squelch_det, fixture_det,
		test_packet_det};

	ushr_sync_bank #(
		.WIDTH    (SYNC_WIDTH)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (raw_pins),
		.sync_out (pins)
	);

	logic       sda_s;
	logic       scl_s;
	logic       dc_hi_s;
	logic       dc_fl_s;
	logic [1:0] ac_sel_s;
	logic       ac_fl_s;
	logic       dp_pu_s;
	logic       dm_pu_s;
	logic       disc_s;
	logic       bus_rst_s;
	logic       chirp_j_s;
	logic       chirp_k_s;
	logic       squelch_s;
	logic       fixture_s;
	logic       test_pkt_s;

	assign {sda_s, scl_s, dc_hi_s, dc_fl_s, ac_sel_s, ac_fl_s, dp_pu_s,
		dm_pu_s, disc_s, bus_rst_s, chirp_j_s, chirp_k_s, squelch_s,
		fixture_s, test_pkt_s} = pins;

	// ----------------------------------------------------------------
	// Strap capture
	// ----------------------------------------------------------------
	// Straps are caught once the synchroniser holds real pin levels,
	// so the first captured value is never the reset constant.
	logic [1:0] strap_wait;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_wait <= 2'h0;
		end else if (strap_wait != SYNC_DONE) begin
			strap_wait <= strap_wait + 2'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			straps_valid     <= 1'b0;
			serial_mode      <= 1'b0;
			ac_boost_setting <= AC_BOOST_MAX;
			dc_gain_setting  <= DC_GAIN_60MV;
		end else if (!straps_valid && strap_wait == SYNC_DONE) begin
			straps_valid     <= 1'b1;
			serial_mode      <= sda_s & scl_s;
			ac_boost_setting <= ac_fl_s ? AC_BOOST_MAX : ac_sel_s;
			if (!(sda_s & scl_s)) begin
				if (dc_fl_s) begin
					dc_gain_setting <= DC_GAIN_60MV;
				end else if (dc_hi_s) begin
					dc_gain_setting <= DC_GAIN_80MV;
				end else begin
					dc_gain_setting <= DC_GAIN_40MV;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Channel state tracking
	// ----------------------------------------------------------------
	ushr_chan_state_type chan_state;
	logic [CNT_W-1:0]    chirp_cnt;

	function automatic logic chirp_in_window(input logic [CNT_W-1:0] c);
		chirp_in_window = (c >= MIN_CNT) && (c <= MAX_CNT);
	endfunction : chirp_in_window

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_state <= CH_UNCONN;
			chirp_cnt  <= '0;
		end else if (!straps_valid) begin
			chan_state <= CH_UNCONN;
			chirp_cnt  <= '0;
		end else begin
			case (chan_state)
				CH_UNCONN: begin
					if (fixture_s) begin
						chan_state <= CH_FIXTURE;
					end else if (dp_pu_s | dm_pu_s) begin
						chan_state <= CH_CONN;
					end
				end
				CH_FIXTURE: begin
					if (disc_s) begin
						chan_state <= CH_UNCONN;
					end else if (test_pkt_s) begin
						chan_state <= CH_HS;
					end
				end
				CH_CONN, CH_HS: begin
					if (disc_s) begin
						chan_state <= CH_UNCONN;
					end else if (bus_rst_s && chirp_j_s) begin
						// A new bus reset restarts the handshake
						chan_state <= CH_CHIRP_J;
						chirp_cnt  <= ONE_CNT;
					end
				end
				CH_CHIRP_J: begin
					if (disc_s) begin
						chan_state <= CH_UNCONN;
					end else if (chirp_j_s) begin
						if (chirp_cnt == MAX_CNT) begin
							chan_state <= CH_CONN;
						end else begin
							chirp_cnt <= chirp_cnt + ONE_CNT;
						end
					end else if (chirp_in_window(chirp_cnt) && chirp_k_s) begin
						chan_state <= CH_CHIRP_K;
						chirp_cnt  <= ONE_CNT;
					end else begin
						chan_state <= CH_CONN;
					end
				end
				CH_CHIRP_K: begin
					if (disc_s) begin
						chan_state <= CH_UNCONN;
					end else if (chirp_k_s) begin
						if (chirp_cnt == MAX_CNT) begin
							chan_state <= CH_CONN;
						end else begin
							chirp_cnt <= chirp_cnt + ONE_CNT;
						end
					end else if (chirp_in_window(chirp_cnt)) begin
						chan_state <= CH_HS_WAIT;
					end else begin
						chan_state <= CH_CONN;
					end
				end
				CH_HS_WAIT: begin
					if (disc_s) begin
						chan_state <= CH_UNCONN;
					end else if (squelch_s) begin
						chan_state <= CH_HS;
					end
				end
				default: begin
					chan_state <= CH_UNCONN;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flags and pin drive
	// ----------------------------------------------------------------
	// Fixture state counts as attached: the fixture presents a device.
	assign connection_flag    = (chan_state != CH_UNCONN);
	assign high_speed_flag    = (chan_state == CH_HS);
	assign core_regulator_out = high_speed_flag;

	// In serial mode both pins stay released apart from the target
	assign scl_out           = connection_flag;
	assign scl_oe            = straps_valid & ~serial_mode;
	assign dc_gain_strap_out = high_speed_flag;
	assign dc_gain_strap_oe  = straps_valid & ~serial_mode;

	// ----------------------------------------------------------------
	// Two-wire serial target
	// ----------------------------------------------------------------
	ushr_ser_state_type ser_state;
	logic               sda_prev;
	logic               scl_prev;
	logic [3:0]         bit_cnt;
	logic [7:0]         shift_in;
	logic [7:0]         shift_out;
	logic               read_dir;
	logic               sda_drive;
	logic               ser_start;
	logic               ser_stop;
	logic               scl_rise;
	logic               scl_fall;
	logic [7:0]         status_byte;

	assign ser_start = scl_s & scl_prev & sda_prev & ~sda_s;
	assign ser_stop  = scl_s & scl_prev & ~sda_prev & sda_s;
	assign scl_rise  = scl_s & ~scl_prev;
	assign scl_fall  = ~scl_s & scl_prev;
	assign status_byte = {2'h0, high_speed_flag, connection_flag,
		1'b0, chan_state};

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe  = sda_drive;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_prev <= 1'b1;
			scl_prev <= 1'b1;
		end else begin
			sda_prev <= sda_s;
			scl_prev <= scl_s;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_state     <= SER_IDLE;
			bit_cnt       <= 4'h0;
			shift_in      <= 8'h00;
			shift_out     <= 8'h00;
			read_dir      <= 1'b0;
			sda_drive     <= 1'b0;
			serial_config <= SER_CFG_RESET;
		end else if (!serial_mode) begin
			ser_state <= SER_IDLE;
			sda_drive <= 1'b0;
		end else if (ser_start) begin
			ser_state <= SER_ADDR_RX;
			bit_cnt   <= 4'h0;
			sda_drive <= 1'b0;
		end else if (ser_stop) begin
			ser_state <= SER_IDLE;
			sda_drive <= 1'b0;
		end else begin
			case (ser_state)
				SER_ADDR_RX, SER_WR_RX: begin
					if (scl_rise && bit_cnt != SER_BYTE_BITS) begin
						shift_in <= {shift_in[6:0], sda_s};
						bit_cnt  <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == SER_BYTE_BITS) begin
						if (ser_state == SER_WR_RX) begin
							serial_config <= shift_in;
							sda_drive     <= 1'b1;
							ser_state     <= SER_ACK_WR;
						end else if (shift_in[7:1] == SER_ADDR) begin
							read_dir  <= shift_in[0];
							sda_drive <= 1'b1;
							ser_state <= SER_ACK_ADR;
						end else begin
							ser_state <= SER_IDLE;
						end
					end
				end
				SER_ACK_ADR, SER_ACK_WR: begin
					if (scl_fall) begin
						if (read_dir) begin
							shift_out <= status_byte;
							sda_drive <= ~status_byte[7];
							bit_cnt   <= 4'h1;
							ser_state <= SER_RD_TX;
						end else begin
							sda_drive <= 1'b0;
							bit_cnt   <= 4'h0;
							ser_state <= SER_WR_RX;
						end
					end
				end
				SER_RD_TX: begin
					if (scl_fall) begin
						if (bit_cnt == SER_BYTE_BITS) begin
							sda_drive <= 1'b0;
							ser_state <= SER_ACK_RD;
						end else begin
							sda_drive <= ~shift_out[6];
							shift_out <= {shift_out[6:0], 1'b0};
							bit_cnt   <= bit_cnt + 4'h1;
						end
					end
				end
				SER_ACK_RD: begin
					// A not-acknowledge ends the read; an acknowledge
					// sends the status again.
					if (scl_rise && sda_s) begin
						ser_state <= SER_IDLE;
					end else if (scl_fall) begin
						shift_out <= status_byte;
						sda_drive <= ~status_byte[7];
						bit_cnt   <= 4'h1;
						ser_state <= SER_RD_TX;
					end
				end
				default: begin
					ser_state <= SER_IDLE;
					sda_drive <= 1'b0;
				end
			endcase
		end
	end

endmodule : ushr_mode_detect

`default_nettype wire

// ===== verilog/ushr_sync_bank.sv
// Two-stage synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none

module ushr_sync_bank #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	// Each bit gets its own pair; the first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					stage_one[i] <= 1'b0;
					sync_out[i]  <= 1'b0;
				end else begin
					stage_one[i] <= async_in[i];
					sync_out[i]  <= stage_one[i];
				end
			end
		end
	endgenerate

endmodule : ushr_sync_bank

`default_nettype wire
